/* File: core/island_image_pkg.sv */
// constants, types and block map of the island data image
package island_image_pkg;

	localparam int unsigned IMAGE_REGS  = 9999;
	localparam int unsigned FIRST_REF   = 40001;
	localparam int unsigned INDEX_W     = 14;
	localparam int unsigned REG_W       = 16;

	// block start indices (reference minus first reference) and sizes
	localparam int unsigned OUT_IMG_BASE = 0;
	localparam int unsigned OUT_IMG_SIZE = 4096;
	localparam int unsigned OUT_TBL_BASE = 4096;
	localparam int unsigned OUT_TBL_SIZE = 512;
	localparam int unsigned RSV3_BASE    = 4608;
	localparam int unsigned RSV3_SIZE    = 512;
	localparam int unsigned RSV4_BASE    = 5120;
	localparam int unsigned RSV4_SIZE    = 9;
	localparam int unsigned XFR_REQ_BASE = 5129;
	localparam int unsigned XFR_REQ_SIZE = 5;
	localparam int unsigned RSV6_BASE    = 5134;
	localparam int unsigned RSV6_SIZE    = 114;
	localparam int unsigned RSV7_BASE    = 5248;
	localparam int unsigned RSV7_SIZE    = 54;
	localparam int unsigned XFR_RSP_BASE = 5302;
	localparam int unsigned XFR_RSP_SIZE = 4;
	localparam int unsigned RSV9_BASE    = 5306;
	localparam int unsigned RSV9_SIZE    = 50;
	localparam int unsigned DIAG_BASE    = 5356;
	localparam int unsigned DIAG_SIZE    = 35;
	localparam int unsigned IN_IMG_BASE  = 5391;
	localparam int unsigned IN_IMG_SIZE  = 4096;
	localparam int unsigned IN_TBL_BASE  = 9487;
	localparam int unsigned IN_TBL_SIZE  = 512;

	// diagnostic registers
	localparam logic [15:0] ISLAND_COMM_STATE_REF = 16'hb12d;
	localparam int unsigned COMM_STATE_IDX = 5356;
	localparam int unsigned MODULE_STATUS_IDX = 5390;
	localparam int unsigned PROTECT_BIT = 11;
	localparam int unsigned TEST_MASTER_BIT = 15;
	localparam logic [7:0]  FLAGS_RESET = 8'h00;
	localparam logic [15:0] RDATA_RESET = 16'h0000;

	localparam int unsigned PW_MAX_LEN = 6;

	typedef enum logic [7:0] {
		ST_INIT        = 8'h01,
		ST_PREOP_RESET = 8'h02,
		ST_CFG_RESET   = 8'h03,
		ST_CFG_CHECK   = 8'h04,
		ST_CFG_ADDR    = 8'h05,
		ST_CFG_BOOT    = 8'h06,
		ST_IMG_SETUP   = 8'h07,
		ST_CFG_IDLE    = 8'h08,
		ST_MIS_OPT     = 8'h09,
		ST_MIS_MAND    = 8'h0a,
		ST_MIS_ABORT   = 8'h0b,
		ST_OPER        = 8'h0c,
		ST_OPER_MIS    = 8'h0d,
		ST_MIS_STOPPED = 8'h0e,
		ST_PREOP_STOP  = 8'h0f
	} comm_state_e;

	typedef struct packed {
		logic               valid;
		logic               write;
		logic [INDEX_W-1:0] index;
		logic [REG_W-1:0]   wdata;
	} hmi_req_s;

	typedef struct packed {
		logic             valid;
		logic [11:0]      index;
		logic [REG_W-1:0] data;
	} src_wr_s;

	typedef struct packed {
		logic [2:0]      len;
		logic [5:0][7:0] chars;
	} pw_s;

endpackage : island_image_pkg

/* File: core/island_pw_check.sv */
// password comparison and character check for configuration protection
module island_pw_check #(
	parameter int unsigned MAX_LEN = island_image_pkg::PW_MAX_LEN
) (
	input  wire island_image_pkg::pw_s stored,
	input  wire island_image_pkg::pw_s cand,
	output logic                       match,
	output logic                       cand_ok
);

	logic [MAX_LEN-1:0] char_eq;
	logic [MAX_LEN-1:0] char_ok;

	if (MAX_LEN != island_image_pkg::PW_MAX_LEN) begin : g_bad_len
		$error("password length must match the stored layout");
	end

	for (genvar i = 0; i < MAX_LEN; i++) begin : g_char
		logic [7:0] c;
		logic       used;
		assign c    = cand.chars[i];
		assign used = (i < int'(cand.len));
		// exact byte compare, so upper and lower case differ
		assign char_eq[i] = !used || (c == stored.chars[i]);
		assign char_ok[i] = !used || (c >= 8'h30 && c <= 8'h39)
			|| (c >= 8'h41 && c <= 8'h5a) || (c >= 8'h61 && c <= 8'h7a);
	end

	always_comb begin
		cand_ok = (int'(cand.len) <= MAX_LEN) && (&char_ok);
		match   = cand_ok && (cand.len == stored.len) && (&char_eq);
	end

endmodule : island_pw_check

/* File: core/island_data_image_status_bank.sv */
// island data image register bank with status register and write protection
module island_data_image_status_bank (
	input  wire logic                           ref_clk,
	input  wire logic                           rst_n,
	input  wire island_image_pkg::hmi_req_s     hmi_req,
	output logic [15:0]                         hmi_rdata,
	output logic                                hmi_ack,
	output logic                                hmi_refused,
	input  wire logic                           test_mode,
	input  wire island_image_pkg::src_wr_s      fb_out_wr,
	input  wire island_image_pkg::src_wr_s      fb_tbl_wr,
	input  wire island_image_pkg::src_wr_s      io_in_wr,
	input  wire island_image_pkg::src_wr_s      xfr_rsp_wr,
	input  wire logic [8:0]                     fb_in_rd_index,
	output logic [15:0]                         fb_in_rd_data,
	input  wire island_image_pkg::comm_state_e  comm_state,
	input  wire logic [7:0]                     err_events,
	input  wire logic                           err_clear,
	input  wire logic                           cfg_save,
	input  wire logic                           cfg_save_protect,
	input  wire island_image_pkg::pw_s          cfg_save_pw,
	input  wire logic                           nvm_wr_req,
	input  wire island_image_pkg::pw_s          nvm_wr_pw,
	output logic                                nvm_wr_grant,
	output logic                                nvm_wr_deny,
	input  wire logic                           rst_button,
	output logic                                cfg_reset,
	input  wire logic                           card_load_req,
	output logic                                card_load,
	output logic                                protected_out
);

	// storage for the blocks that hold data; everything else but the two diagnostic words reads zero
	logic [15:0] out_img [island_image_pkg::OUT_IMG_SIZE];
	logic [15:0] out_tbl [island_image_pkg::OUT_TBL_SIZE];
	// request block is written by the panel, response block only by its source
	logic [15:0] xfr_req [island_image_pkg::XFR_REQ_SIZE];
	logic [15:0] xfr_rsp [island_image_pkg::XFR_RSP_SIZE];
	logic [15:0] in_img  [island_image_pkg::IN_IMG_SIZE];
	logic [15:0] in_tbl  [island_image_pkg::IN_TBL_SIZE];

	// bus side state
	logic [15:0] rdata_reg,   rdata_next;
	logic        ack_reg,     ack_next;
	logic        refused_reg, refused_next;
	logic [15:0] fb_rd_reg,   fb_rd_next;

	// status and protection state
	logic [7:0]             flags_reg,   flags_next;
	logic                   protect_reg, protect_next;
	island_image_pkg::pw_s  pw_reg,      pw_next;
	logic                   grant_reg,   grant_next;
	logic                   deny_reg,    deny_next;
	logic                   creset_reg,  creset_next;
	logic                   card_reg,    card_next;

	// memory write controls
	logic        oi_we;
	logic [11:0] oi_idx;
	logic [15:0] oi_d;
	logic        it_we;
	logic [8:0]  it_idx;
	logic        rq_we;
	logic [2:0]  rq_idx;

	logic        pw_match;
	logic        pw_cand_ok;
	logic        save_ok;

	island_pw_check #(
		.MAX_LEN (island_image_pkg::PW_MAX_LEN)
	) u_pw_check (
		.stored  (pw_reg),
		.cand    (nvm_wr_pw),
		.match   (pw_match),
		.cand_ok (pw_cand_ok)
	);

	island_pw_check #(
		.MAX_LEN (island_image_pkg::PW_MAX_LEN)
	) u_pw_save (
		.stored  (pw_reg),
		.cand    (cfg_save_pw),
		.match   (),
		.cand_ok (save_ok)
	);

	function automatic logic in_blk(input logic [13:0] idx, input int unsigned base,
			input int unsigned size);
		in_blk = (int'(idx) >= base) && (int'(idx) < base + size);
	endfunction : in_blk

	// ---- panel access: reads everywhere, writes by block ----
	always_comb begin
		logic [13:0] ix;
		ix           = hmi_req.index;
		rdata_next   = island_image_pkg::RDATA_RESET;
		ack_next     = hmi_req.valid;
		refused_next = 1'b0;
		oi_we        = 1'b0;
		oi_idx       = fb_out_wr.index;
		oi_d         = fb_out_wr.data;
		it_we        = 1'b0;
		it_idx       = ix[8:0] - 9'(island_image_pkg::IN_TBL_BASE);
		rq_we        = 1'b0;
		rq_idx       = 3'(ix - 14'(island_image_pkg::XFR_REQ_BASE));
		// fixed bases: each block decodes from a constant start
		// indices past the last block match nothing and read zero
		if (in_blk(ix, island_image_pkg::OUT_IMG_BASE, island_image_pkg::OUT_IMG_SIZE)) begin
			rdata_next = out_img[ix[11:0]];
		end else if (in_blk(ix, island_image_pkg::OUT_TBL_BASE,
				island_image_pkg::OUT_TBL_SIZE)) begin
			rdata_next = out_tbl[ix[8:0]];
		end else if (in_blk(ix, island_image_pkg::XFR_REQ_BASE,
				island_image_pkg::XFR_REQ_SIZE)) begin
			rdata_next = xfr_req[rq_idx];
		end else if (in_blk(ix, island_image_pkg::XFR_RSP_BASE,
				island_image_pkg::XFR_RSP_SIZE)) begin
			rdata_next = xfr_rsp[2'(ix - 14'(island_image_pkg::XFR_RSP_BASE))];
		end else if (int'(ix) == island_image_pkg::COMM_STATE_IDX) begin
			// state code passes straight through; its source owns the encoding
			rdata_next = {flags_reg, comm_state};
		end else if (int'(ix) == island_image_pkg::MODULE_STATUS_IDX) begin
			// only two bits of this diagnostic word are modelled
			rdata_next[island_image_pkg::PROTECT_BIT]     = protect_reg;
			rdata_next[island_image_pkg::TEST_MASTER_BIT] = test_mode;
		end else if (in_blk(ix, island_image_pkg::IN_IMG_BASE,
				island_image_pkg::IN_IMG_SIZE)) begin
			rdata_next = in_img[12'(ix - 14'(island_image_pkg::IN_IMG_BASE))];
		end else if (in_blk(ix, island_image_pkg::IN_TBL_BASE,
				island_image_pkg::IN_TBL_SIZE)) begin
			rdata_next = in_tbl[it_idx];
		end
		if (!hmi_req.valid || hmi_req.write) begin
			rdata_next = rdata_reg;
		end
		// output image source follows who is island bus master
		if (test_mode) begin
			oi_we  = hmi_req.valid && hmi_req.write
				&& in_blk(ix, island_image_pkg::OUT_IMG_BASE, island_image_pkg::OUT_IMG_SIZE);
			oi_idx = ix[11:0];
			oi_d   = hmi_req.wdata;
		end else begin
			oi_we  = fb_out_wr.valid;
		end
		if (hmi_req.valid && hmi_req.write) begin
			if (in_blk(ix, island_image_pkg::OUT_IMG_BASE, island_image_pkg::OUT_IMG_SIZE)) begin
				refused_next = !test_mode;
			end else if (in_blk(ix, island_image_pkg::IN_TBL_BASE,
					island_image_pkg::IN_TBL_SIZE)) begin
				it_we = 1'b1;
			end else if (in_blk(ix, island_image_pkg::XFR_REQ_BASE,
					island_image_pkg::XFR_REQ_SIZE)) begin
				rq_we = 1'b1;
			end else begin
				// reserved blocks hold no storage yet and source-owned blocks belong to their source, so writes here are refused
				refused_next = 1'b1;
			end
		end
		fb_rd_next = in_tbl[fb_in_rd_index];
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg   <= island_image_pkg::RDATA_RESET;
			ack_reg     <= 1'b0;
			refused_reg <= 1'b0;
			fb_rd_reg   <= island_image_pkg::RDATA_RESET;
		end else begin
			rdata_reg   <= rdata_next;
			ack_reg     <= ack_next;
			refused_reg <= refused_next;
			fb_rd_reg   <= fb_rd_next;
		end
	end

	// memories have no reset; contents are data, not control
	always_ff @(posedge ref_clk) begin
		if (oi_we) out_img[oi_idx] <= oi_d;
		if (fb_tbl_wr.valid) out_tbl[fb_tbl_wr.index[8:0]] <= fb_tbl_wr.data;
		if (io_in_wr.valid) in_img[io_in_wr.index] <= io_in_wr.data;
		if (xfr_rsp_wr.valid) xfr_rsp[xfr_rsp_wr.index[1:0]] <= xfr_rsp_wr.data;
		// input table is panel-written and read out to the master one cycle later
		if (it_we) in_tbl[it_idx] <= hmi_req.wdata;
		if (rq_we) xfr_req[rq_idx] <= hmi_req.wdata;
	end

	// ---- status flags and configuration protection ----
	always_comb begin
		// flag bits map to status bits 15..8; a new event beats a same-cycle clear
		flags_next   = (flags_reg & ~{8{err_clear}}) | err_events;
		protect_next = protect_reg;
		pw_next      = pw_reg;
		if (cfg_save && save_ok) begin
			protect_next = cfg_save_protect;
			pw_next      = cfg_save_pw;
		end
		grant_next  = nvm_wr_req && (!protect_reg || pw_match);
		deny_next   = nvm_wr_req && protect_reg && !pw_match;
		creset_next = rst_button && !protect_reg;
		card_next   = card_load_req && !protect_reg;
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			flags_reg   <= island_image_pkg::FLAGS_RESET;
			protect_reg <= 1'b0;
			pw_reg      <= '0;
			grant_reg   <= 1'b0;
			deny_reg    <= 1'b0;
			creset_reg  <= 1'b0;
			card_reg    <= 1'b0;
		end else begin
			flags_reg   <= flags_next;
			protect_reg <= protect_next;
			pw_reg      <= pw_next;
			grant_reg   <= grant_next;
			deny_reg    <= deny_next;
			creset_reg  <= creset_next;
			card_reg    <= card_next;
		end
	end

	assign hmi_rdata     = rdata_reg;
	assign hmi_ack       = ack_reg;
	assign hmi_refused   = refused_reg;
	assign fb_in_rd_data = fb_rd_reg;
	assign nvm_wr_grant  = grant_reg;
	assign nvm_wr_deny   = deny_reg;
	assign cfg_reset     = creset_reg;
	assign card_load     = card_reg;
	assign protected_out = protect_reg;

	// ---- checks ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	read_ack_a: assert property (hmi_req.valid |=> hmi_ack)
		else $error("request not acknowledged next cycle");
	oi_guard_a: assert property (hmi_req.valid && hmi_req.write && !test_mode
			&& hmi_req.index < 14'(island_image_pkg::OUT_TBL_BASE) |=> hmi_refused)
		else $error("output image write outside test mode not refused");
	bus_off_a: assert property (err_events[2] |=> flags_reg[2] [*1] ##1 (flags_reg[2] || $past(err_clear)))
		else $error("bus-off flag not held");
	set_wins_a: assert property (err_clear && err_events[0] |=> flags_reg[0])
		else $error("event lost against clear");
	button_block_a: assert property (protect_reg && rst_button |=> !cfg_reset)
		else $error("reset button acted while protected");
	card_ignore_a: assert property (protect_reg && card_load_req |=> !card_load)
		else $error("card accepted while protected");
	nvm_deny_a: assert property (nvm_wr_req && protect_reg && !pw_match
			|=> nvm_wr_deny && !nvm_wr_grant)
		else $error("unauthorised configuration write granted");
	comm_read_a: assert property (hmi_req.valid && !hmi_req.write
			&& hmi_req.index == 14'(island_image_pkg::COMM_STATE_IDX)
			|=> hmi_rdata == {$past(flags_reg), 8'($past(comm_state))})
		else $error("communications status read wrong");
	rsv_zero_a: assert property (hmi_req.valid && !hmi_req.write
			&& hmi_req.index == 14'(island_image_pkg::RSV9_BASE) |=> hmi_rdata == 16'h0000)
		else $error("reserved register read nonzero");

	// decode edges: past the image and the module status word
	range_zero_a: assert property (hmi_req.valid && !hmi_req.write
			&& hmi_req.index >= 14'(island_image_pkg::IMAGE_REGS) |=> hmi_rdata == 16'h0000)
		else $error("read past the image nonzero");
	status_read_a: assert property (hmi_req.valid && !hmi_req.write
			&& hmi_req.index == 14'(island_image_pkg::MODULE_STATUS_IDX)
			|=> hmi_rdata == {$past(test_mode), 3'h0, $past(protect_reg), 11'h000})
		else $error("module status read wrong");

	// bus answer shape
	refused_ack_a: assert property (hmi_refused |-> hmi_ack)
		else $error("refusal without acknowledge");
	oi_accept_a: assert property (hmi_req.valid && hmi_req.write && test_mode
			&& hmi_req.index < 14'(island_image_pkg::OUT_TBL_BASE) |=> !hmi_refused)
		else $error("output image write in test mode refused");
	it_write_a: assert property (hmi_req.valid && hmi_req.write
			&& hmi_req.index >= 14'(island_image_pkg::IN_TBL_BASE)
			&& hmi_req.index < 14'(island_image_pkg::IMAGE_REGS) |=> !hmi_refused)
		else $error("input table write refused");

	// sticky flags and protection gates
	flags_hold_a: assert property (!err_clear
			|=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
		else $error("status flag dropped without clear");
	button_free_a: assert property (!protect_reg && rst_button |=> cfg_reset)
		else $error("reset button ignored while unprotected");
	card_free_a: assert property (!protect_reg && card_load_req |=> card_load)
		else $error("card load ignored while unprotected");
	nvm_grant_a: assert property (nvm_wr_req && (!protect_reg || pw_match)
			|=> nvm_wr_grant && !nvm_wr_deny)
		else $error("authorised configuration write not granted");
	save_ignore_a: assert property (cfg_save && !save_ok
			|=> protect_reg == $past(protect_reg) && pw_reg == $past(pw_reg))
		else $error("invalid password accepted");

	oi_write_c: cover property (test_mode && hmi_req.valid && hmi_req.write);
	grant_c:    cover property (protect_reg && nvm_wr_req && pw_match);
	flag_c:     cover property (err_events[7] ##1 err_clear);
	refuse_c:   cover property (hmi_req.valid && hmi_req.write ##1 hmi_refused);
	card_c:     cover property (!protect_reg && card_load_req ##1 card_load);

endmodule : island_data_image_status_bank

/* File: sim/hmi_panel_model.sv */
// panel-side model issuing single-register accesses on the image bus
module hmi_panel_model (
	input  wire logic                  ref_clk,
	input  wire logic [15:0]           hmi_rdata,
	input  wire logic                  hmi_ack,
	input  wire logic                  hmi_refused,
	output island_image_pkg::hmi_req_s hmi_req
);
	timeunit 1ns;
	timeprecision 1ns;

	initial hmi_req = '0;

	// one pulse per access; answer taken exactly one cycle after the take edge
	task automatic access(
		input  logic        write,
		input  logic [13:0] index,
		input  logic [15:0] wdata,
		output logic [15:0] rdata,
		output logic        refused
	);
		@(posedge ref_clk);
		hmi_req <= '{valid: 1'b1, write: write, index: index, wdata: wdata};
		@(posedge ref_clk);
		// released lines show inverted values so stale data cannot pass
		hmi_req <= '{valid: 1'b0, write: ~write, index: ~index, wdata: ~wdata};
		@(posedge ref_clk);
		if (hmi_ack === 1'b1) begin
			rdata = hmi_rdata;
			refused = hmi_refused;
		end else begin
			rdata = 16'hxxxx;
			refused = 1'bx;
		end
	endtask : access
endmodule : hmi_panel_model

/* File: sim/tb_island_data_image_status_bank.sv */
// testbench for the island data image and status bank
module tb_island_data_image_status_bank;
	timeunit 1ns;
	timeprecision 1ns;
	logic                          ref_clk = 1'b0;
	logic                          rst_n;
	logic                          test_mode;
	logic                          err_clear;
	logic                          cfg_save_protect;
	logic [3:0]                    strb;
	wire  [3:0]                    evt;
	logic [7:0]                    err_events;
	logic [8:0]                    fb_in_rd_index;
	logic [15:0]                   hmi_rdata;
	logic [15:0]                   fb_in_rd_data;
	logic                          hmi_ack;
	logic                          hmi_refused;
	logic                          protected_out;
	island_image_pkg::hmi_req_s    hmi_req;
	island_image_pkg::src_wr_s     src [4];
	island_image_pkg::comm_state_e comm_state;
	island_image_pkg::pw_s         save_pw;
	island_image_pkg::pw_s         nvm_pw;
	int                            fail_count = 0;
	int                            compares = 0;
	localparam logic [13:0] SI = 14'(island_image_pkg::COMM_STATE_IDX);
	localparam logic [13:0] NI = 14'(island_image_pkg::MODULE_STATUS_IDX);
	localparam logic [13:0] TI = 14'(island_image_pkg::IN_TBL_BASE);

	always #50 ref_clk = ~ref_clk;

	island_data_image_status_bank island_data_image_status_bank_inst (
		.ref_clk(ref_clk), .rst_n(rst_n), .hmi_req(hmi_req), .hmi_rdata(hmi_rdata),
		.hmi_ack(hmi_ack), .hmi_refused(hmi_refused), .test_mode(test_mode),
		.fb_out_wr(src[0]), .fb_tbl_wr(src[1]), .io_in_wr(src[2]), .xfr_rsp_wr(src[3]),
		.fb_in_rd_index(fb_in_rd_index), .fb_in_rd_data(fb_in_rd_data),
		.comm_state(comm_state), .err_events(err_events), .err_clear(err_clear),
		.cfg_save(strb[0]), .cfg_save_protect(cfg_save_protect), .cfg_save_pw(save_pw),
		.nvm_wr_req(strb[1]), .nvm_wr_pw(nvm_pw), .nvm_wr_grant(evt[0]),
		.nvm_wr_deny(evt[1]), .rst_button(strb[2]), .cfg_reset(evt[2]),
		.card_load_req(strb[3]), .card_load(evt[3]), .protected_out(protected_out));

	hmi_panel_model hmi_panel_model_inst (
		.ref_clk(ref_clk), .hmi_rdata(hmi_rdata), .hmi_ack(hmi_ack),
		.hmi_refused(hmi_refused), .hmi_req(hmi_req));

	task automatic print_verdict();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [13:0] i, input logic [15:0] exp);
		logic [15:0] d;
		logic        r;
		hmi_panel_model_inst.access(1'b0, i, 16'h0000, d, r);
		chk(d, exp, $sformatf("read %h", i));
	endtask : rd

	task automatic wr(input logic [13:0] i, input logic [15:0] v, input logic rf);
		logic [15:0] d;
		logic        r;
		hmi_panel_model_inst.access(1'b1, i, v, d, r);
		chk({15'h0000, r}, {15'h0000, rf}, $sformatf("refusal %h", i));
	endtask : wr

	task automatic src_put(input int w, input logic [11:0] i, input logic [15:0] v);
		@(posedge ref_clk);
		src[w] <= {1'b1, i, v};
		@(posedge ref_clk);
		src[w] <= '0;
	endtask : src_put

	// strb: save, nvm write, reset button, card; evt: grant, deny, cfg reset, card load
	task automatic strobe(input logic [3:0] m, input logic [3:0] exp);
		@(posedge ref_clk);
		strb <= m;
		@(posedge ref_clk);
		strb <= 4'h0;
		@(posedge ref_clk);
		chk({12'h000, evt}, {12'h000, exp}, "strobe answer");
	endtask : strobe

	task automatic save(input logic p, input island_image_pkg::pw_s pw, input logic exp);
		@(posedge ref_clk);
		cfg_save_protect <= p;
		save_pw <= pw;
		strobe(4'h1, 4'h0);
		chk({15'h0000, protected_out}, {15'h0000, exp}, "protection");
	endtask : save

	task automatic t_states();
		for (int c = 1; c <= 15; c++) begin
			@(posedge ref_clk);
			comm_state <= island_image_pkg::comm_state_e'(c);
			rd(SI, {8'h00, 8'(c)});
		end
	endtask : t_states

	task automatic t_flags();
		logic [7:0] f;
		f = 8'h00;
		for (int b = 0; b < 8; b++) begin
			@(posedge ref_clk);
			err_events <= 8'h01 << b;
			@(posedge ref_clk);
			err_events <= 8'h00;
			f = f | (8'h01 << b);
			rd(SI, {f, 8'h0f});
		end
		@(posedge ref_clk);
		err_clear <= 1'b1;
		err_events <= 8'h05;
		@(posedge ref_clk);
		err_clear <= 1'b0;
		err_events <= 8'h00;
		rd(SI, 16'h050f);
		@(posedge ref_clk);
		err_clear <= 1'b1;
		@(posedge ref_clk);
		err_clear <= 1'b0;
		rd(SI, 16'h000f);
	endtask : t_flags

	task automatic t_map();
		int unsigned rsv [8] = '{island_image_pkg::RSV3_BASE, island_image_pkg::RSV4_BASE + 8,
			island_image_pkg::RSV6_BASE, island_image_pkg::RSV7_BASE + 53,
			island_image_pkg::RSV9_BASE, island_image_pkg::RSV9_BASE + 49,
			island_image_pkg::DIAG_BASE + 1, 9999};
		int unsigned bs [4] = '{island_image_pkg::OUT_IMG_BASE, island_image_pkg::OUT_TBL_BASE,
			island_image_pkg::IN_IMG_BASE, island_image_pkg::XFR_RSP_BASE};
		int unsigned offs [4] = '{4095, 511, 4095, 3};
		logic [15:0] v;
		for (int k = 0; k < 8; k++) begin
			wr(14'(rsv[k]), 16'hffff, 1'b1);
			rd(14'(rsv[k]), 16'h0000);
		end
		// source-owned blocks: visible to the panel, panel writes refused
		for (int k = 0; k < 4; k++) begin
			v = {4'(k), 12'h9c3};
			src_put(k, 12'(offs[k]), v);
			rd(14'(bs[k] + offs[k]), v);
			wr(14'(bs[k] + offs[k]), ~v, 1'b1);
			rd(14'(bs[k] + offs[k]), v);
		end
		wr(TI, 16'ha5c3, 1'b0);
		rd(TI, 16'ha5c3);
		wr(TI + 14'h01ff, 16'h3c5a, 1'b0);
		rd(TI + 14'h01ff, 16'h3c5a);
		wr(14'(island_image_pkg::XFR_REQ_BASE + 4), 16'h1234, 1'b0);
		rd(14'(island_image_pkg::XFR_REQ_BASE + 4), 16'h1234);
		@(posedge ref_clk);
		fb_in_rd_index <= 9'h1ff;
		@(posedge ref_clk);
		@(posedge ref_clk);
		chk(fb_in_rd_data, 16'h3c5a, "input table to master");
	endtask : t_map

	task automatic t_test();
		@(posedge ref_clk);
		test_mode <= 1'b1;
		wr(14'h0000, 16'h5a5a, 1'b0);
		src_put(0, 12'h000, 16'h0bad);
		rd(14'h0000, 16'h5a5a);
		rd(NI, 16'h8000);
		@(posedge ref_clk);
		test_mode <= 1'b0;
	endtask : t_test

	task automatic t_protect();
		@(posedge ref_clk);
		nvm_pw <= {3'h3, 48'h0000_0031_6241};
		save(1'b1, {3'h3, 48'h0000_0031_6241}, 1'b1);
		rd(NI, 16'h0800);
		rd(TI, 16'ha5c3);
		strobe(4'h4, 4'h0);
		strobe(4'h8, 4'h0);
		strobe(4'h2, 4'h1);
		@(posedge ref_clk);
		nvm_pw <= {3'h3, 48'h0000_0031_4261};
		strobe(4'h2, 4'h2);
		save(1'b0, {3'h7, 48'h3131_3131_3131}, 1'b1);
		save(1'b0, {3'h2, 48'h0000_0000_2d41}, 1'b1);
		save(1'b0, '0, 1'b0);
		strobe(4'h4, 4'h4);
		strobe(4'h8, 4'h8);
		strobe(4'h2, 4'h1);
		save(1'b1, {3'h6, 48'h5161_305a_7a39}, 1'b1);
		strobe(4'h2, 4'h2);
	endtask : t_protect

	initial begin
		rst_n = 1'b0;
		test_mode = 1'b0;
		err_clear = 1'b0;
		cfg_save_protect = 1'b0;
		strb = 4'h0;
		err_events = 8'h00;
		fb_in_rd_index = 9'h000;
		src = '{default: '0};
		comm_state = island_image_pkg::ST_INIT;
		save_pw = '0;
		nvm_pw = '0;
		repeat (16) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		chk({15'h0000, protected_out}, 16'h0000, "protection after reset");
		t_states();
		t_flags();
		t_map();
		t_test();
		t_protect();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		$display("[ERR] %0t watchdog expired", $time);
		print_verdict();
	end
endmodule : tb_island_data_image_status_bank
